/* File: pkg/mma_pkg.sv */
// Shared constants, modes and carrier types of the multiply-accumulate peripheral
`default_nettype none
package mma_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Data widths
    localparam int unsigned DATA_W = 16;             // Operand and register width
    localparam int unsigned PROD_W = 32;             // Product and accumulator width

    ////////////////////////////////////////////////////////////////////////////
    // Byte addresses of the peripheral registers
    localparam logic [15:0] ADDR_OP1_UMUL = 16'h0130; // First operand, unsigned product
    localparam logic [15:0] ADDR_OP1_SMUL = 16'h0132; // First operand, signed product
    localparam logic [15:0] ADDR_OP1_UACC = 16'h0134; // First operand, unsigned accumulate
    localparam logic [15:0] ADDR_OP1_SACC = 16'h0136; // First operand, signed accumulate
    localparam logic [15:0] ADDR_OP2      = 16'h0138; // Second operand, launches the operation
    localparam logic [15:0] ADDR_RES_LO   = 16'h013A; // Result low word
    localparam logic [15:0] ADDR_RES_HI   = 16'h013C; // Result high word
    localparam logic [15:0] ADDR_SUM_EXT  = 16'h013E; // Sum extension word

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset and fixed field values
    localparam logic [15:0] WORD_RESET = 16'h0000;   // All data registers after reset
    localparam logic [15:0] EXT_ZERO   = 16'h0000;   // Positive, zero or no carry
    localparam logic [15:0] EXT_ONES   = 16'hFFFF;   // Negative result
    localparam logic [7:0]  BYTE_ZERO  = 8'h00;      // Upper byte of a zero-extended byte
    localparam logic [7:0]  BYTE_ONES  = 8'hFF;      // Upper byte of a negative byte

    ////////////////////////////////////////////////////////////////////////////
    // Timing: second-operand write to readable result, in main-clock cycles
    localparam int unsigned RESULT_CYCLES = 3;       // Longest allowed latency
    localparam int unsigned PIPE_CYCLES   = 2;       // Latency actually built

    ////////////////////////////////////////////////////////////////////////////
    // Operation modes, one-hot
    typedef enum logic [3:0] {
        MMA_UMUL = 4'b0001,                          // Unsigned product
        MMA_SMUL = 4'b0010,                          // Signed product
        MMA_UACC = 4'b0100,                          // Unsigned accumulate
        MMA_SACC = 4'b1000                           // Signed accumulate
    } mma_mode_t;

    // Processor access to the peripheral space
    typedef struct packed {
        logic [15:0] addr;                           // Byte address
        logic [15:0] wdata;                          // Write data, bytes in low lane
        logic        wen;                            // Write strobe
        logic        ren;                            // Read strobe
        logic        byte_acc;                       // Byte-wide access
    } mma_bus_req_t;

    // Three result words stored together
    typedef struct packed {
        logic [15:0] ext;                            // Sum extension word
        logic [15:0] hi;                             // Result high word
        logic [15:0] lo;                             // Result low word
    } mma_result_t;

endpackage
`default_nettype wire

/* File: core/mma_mul_unit.sv */
// Registered 16x16 multiplier stage, signed or unsigned
`timescale 1ns/10ps
`default_nettype none
module mma_mul_unit #(
    parameter int unsigned W = mma_pkg::DATA_W
) (
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                sys_rst,
    // Launch request
    input  wire logic                start,
    input  wire mma_pkg::mma_mode_t  mode,
    input  wire logic [W-1:0]        op_a,
    input  wire logic [W-1:0]        op_b,
    // Registered product
    output logic                     prod_valid_q,
    output mma_pkg::mma_mode_t       prod_mode_q,
    output logic [2*W-1:0]           prod_q
);

    logic            is_signed;                      // Signed product wanted
    logic [2*W-1:0]  prod_d;                         // Combinational product

    // Operands are already extended to W bits, so one multiplier serves all sizes
    always_comb begin
        is_signed = (mode == mma_pkg::MMA_SMUL) || (mode == mma_pkg::MMA_SACC);
        // Operands widened to 2W first: the low 2W bits then hold the whole product
        if (is_signed) begin
            prod_d = {{W{op_a[W-1]}}, op_a} * {{W{op_b[W-1]}}, op_b};
        end else begin
            prod_d = {{W{1'b0}}, op_a} * {{W{1'b0}}, op_b};
        end
    end

    // Product register, the first pipeline stage
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prod_valid_q <= 1'b0;
            prod_mode_q  <= mma_pkg::MMA_UMUL;
            prod_q       <= '0;
        end else begin
            prod_valid_q <= start;
            if (start) begin
                prod_mode_q <= mode;
                prod_q      <= prod_d;
            end
        end
    end

endmodule
`default_nettype wire

/* File: core/mma_acc_unit.sv */
// Combinational result former: product or accumulate, plus sum extension
`timescale 1ns/10ps
`default_nettype none
module mma_acc_unit (
    // Inputs
    input  wire mma_pkg::mma_mode_t   mode,
    input  wire logic [31:0]          product,
    input  wire logic [31:0]          acc_in,
    // Next result words
    output mma_pkg::mma_result_t      res_d
);

    logic [32:0] sum;                                // Accumulation with carry out

    // Plain 33-bit add; signed accumulate just reads bit 31 of the wrapped sum
    always_comb begin
        sum = {1'b0, acc_in} + {1'b0, product};
        case (mode)
            mma_pkg::MMA_SMUL: begin
                res_d = {{16{product[31]}}, product};
            end
            mma_pkg::MMA_UACC: begin
                res_d = {15'h0000, sum[32], sum[31:0]};
            end
            mma_pkg::MMA_SACC: begin
                res_d = {{16{sum[31]}}, sum[31:0]};
            end
            default: begin
                res_d = {mma_pkg::EXT_ZERO, product};
            end
        endcase
    end

endmodule
`default_nettype wire

/* File: core/mma_top.sv */
// Memory-mapped multiply and multiply-accumulate peripheral, register side
//
// Overview of operation
// - First-operand address picks mode, no start
// - Second-operand write launches selected operation
// - Result readable within three clock cycles
// - First operand and mode persist across launches
// - Low word is always result bits 15:0
// - Unsigned modes: high word is bits 31:16
// - Signed product: high word two's complement
// - Signed accumulate: high word two's complement
// - Unsigned product: extension word is zero
// - Signed modes: extension word is sign
// - Unsigned accumulate: extension word is carry
// - Signed accumulate wraps, no overflow flag
// - Wrapped sum sign sets extension word
// - Signed byte operands are sign-extended
// - Each operand may be byte or word
`timescale 1ns/10ps
`default_nettype none
module mma_top (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  sys_rst,
    // Processor peripheral access
    input  wire mma_pkg::mma_bus_req_t bus_req,
    output logic [15:0]                rdata_q
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    mma_pkg::mma_mode_t   mode_q;                    // Mode picked by last first-operand write
    logic [15:0]          op1_q;                     // Stored first operand, extended
    logic [15:0]          op2_q;                     // Stored second operand, extended
    mma_pkg::mma_result_t res_q;                     // Result words
    mma_pkg::mma_result_t res_d;                     // Result words from the former
    logic                 launch_q;                  // Operation launched last edge
    logic                 prod_valid;                // Product registered last edge
    mma_pkg::mma_mode_t   prod_mode;                 // Mode travelling with the product
    logic [31:0]          prod;                      // Registered product
    logic                 res_done_q;                // Results updated last edge

    // Address decode strobes
    logic                 wr_even;                   // Word or low-byte write
    logic                 wr_op1;                    // Write to any first-operand address
    logic                 wr_op2;                    // Write to second operand
    logic                 wr_lo;                     // Write to result low
    logic                 wr_hi;                     // Write to result high
    mma_pkg::mma_mode_t   mode_d;                    // Mode named by the address
    logic                 mode_signed;               // Address names a signed mode
    logic                 op2_signed;                // Second operand sees a signed mode
    logic [15:0]          wr_word;                   // Write data, byte already extended
    logic [15:0]          wr_op2_word;               // Second-operand data, extended
    logic [15:0]          rd_word;                   // Read mux output

    ////////////////////////////////////////////////////////////////////////////
    // Write decode

    // Odd byte addresses hit nothing; a word sits on the even address only
    always_comb begin
        wr_even = bus_req.wen && !bus_req.addr[0];
        wr_op1  = 1'b0;
        wr_op2  = 1'b0;
        wr_lo   = 1'b0;
        wr_hi   = 1'b0;
        mode_d  = mode_q;
        if (wr_even && bus_req.addr == mma_pkg::ADDR_OP1_UMUL) begin
            wr_op1 = 1'b1;
            mode_d = mma_pkg::MMA_UMUL;
        end else if (wr_even && bus_req.addr == mma_pkg::ADDR_OP1_SMUL) begin
            wr_op1 = 1'b1;
            mode_d = mma_pkg::MMA_SMUL;
        end else if (wr_even && bus_req.addr == mma_pkg::ADDR_OP1_UACC) begin
            wr_op1 = 1'b1;
            mode_d = mma_pkg::MMA_UACC;
        end else if (wr_even && bus_req.addr == mma_pkg::ADDR_OP1_SACC) begin
            wr_op1 = 1'b1;
            mode_d = mma_pkg::MMA_SACC;
        end else if (wr_even && bus_req.addr == mma_pkg::ADDR_OP2) begin
            wr_op2 = 1'b1;
        end else if (wr_even && bus_req.addr == mma_pkg::ADDR_RES_LO) begin
            wr_lo = 1'b1;
        end else if (wr_even && bus_req.addr == mma_pkg::ADDR_RES_HI) begin
            wr_hi = 1'b1;
        end
    end

    // Byte data is widened here once, so the multiplier only sees 16 bits
    always_comb begin
        mode_signed = wr_op1 && ((mode_d == mma_pkg::MMA_SMUL) || (mode_d == mma_pkg::MMA_SACC));
        op2_signed  = (mode_q == mma_pkg::MMA_SMUL) || (mode_q == mma_pkg::MMA_SACC);
        if (!bus_req.byte_acc) begin
            wr_word     = bus_req.wdata;
            wr_op2_word = bus_req.wdata;
        end else begin
            // Plain byte: upper lane cleared
            wr_word     = {mma_pkg::BYTE_ZERO, bus_req.wdata[7:0]};
            wr_op2_word = {mma_pkg::BYTE_ZERO, bus_req.wdata[7:0]};
            if (mode_signed && bus_req.wdata[7]) begin
                wr_word[15:8] = mma_pkg::BYTE_ONES;
            end
            if (op2_signed && bus_req.wdata[7]) begin
                wr_op2_word[15:8] = mma_pkg::BYTE_ONES;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // First operand and mode

    // Held until the next first-operand write, so repeated launches reuse it
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_q <= mma_pkg::MMA_UMUL;
            op1_q  <= mma_pkg::WORD_RESET;
        end else if (wr_op1) begin
            mode_q <= mode_d;
            op1_q  <= wr_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Second operand and launch

    // A second-operand write is the only thing that starts work
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            op2_q    <= mma_pkg::WORD_RESET;
            launch_q <= 1'b0;
        end else begin
            launch_q <= wr_op2;
            if (wr_op2) begin
                op2_q <= wr_op2_word;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Datapath

    // Mode is sampled at launch; a later first-operand write cannot reach it
    mma_mul_unit #(
        .W            (mma_pkg::DATA_W)
    ) mma_mul_unit_inst (
        .ref_clk      (ref_clk),
        .sys_rst      (sys_rst),
        .start        (launch_q),
        .mode         (mode_q),
        .op_a         (op1_q),
        .op_b         (op2_q),
        .prod_valid_q (prod_valid),
        .prod_mode_q  (prod_mode),
        .prod_q       (prod)
    );

    // Accumulates into whatever the result words hold, software writes included
    mma_acc_unit mma_acc_unit_inst (
        .mode    (prod_mode),
        .product (prod),
        .acc_in  ({res_q.hi, res_q.lo}),
        .res_d   (res_d)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Result registers

    // The pipeline wins over a software write in the same cycle; back-to-back
    // launches chain because each store reads the previous store's words.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            res_q      <= '0;
            res_done_q <= 1'b0;
        end else begin
            res_done_q <= prod_valid;
            if (prod_valid) begin
                res_q <= res_d;
            end else begin
                if (wr_lo) begin
                    res_q.lo <= wr_word;
                end
                if (wr_hi) begin
                    res_q.hi <= wr_word;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    // Unmapped and odd addresses read as zero
    always_comb begin
        if (bus_req.addr[0]) begin
            rd_word = mma_pkg::WORD_RESET;
        end else if (bus_req.addr == mma_pkg::ADDR_OP1_UMUL ||
                     bus_req.addr == mma_pkg::ADDR_OP1_SMUL ||
                     bus_req.addr == mma_pkg::ADDR_OP1_UACC ||
                     bus_req.addr == mma_pkg::ADDR_OP1_SACC) begin
            rd_word = op1_q;
        end else if (bus_req.addr == mma_pkg::ADDR_OP2) begin
            rd_word = op2_q;
        end else if (bus_req.addr == mma_pkg::ADDR_RES_LO) begin
            rd_word = res_q.lo;
        end else if (bus_req.addr == mma_pkg::ADDR_RES_HI) begin
            rd_word = res_q.hi;
        end else if (bus_req.addr == mma_pkg::ADDR_SUM_EXT) begin
            rd_word = res_q.ext;
        end else begin
            rd_word = mma_pkg::WORD_RESET;
        end
    end

    // Read data one edge after the strobe; byte reads clear the upper lane
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= mma_pkg::WORD_RESET;
        end else if (bus_req.ren) begin
            if (bus_req.byte_acc) begin
                rdata_q <= {mma_pkg::BYTE_ZERO, rd_word[7:0]};
            end else begin
                rdata_q <= rd_word;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // Mode picked by address, nothing launched
    mode_select_a: assert property (
        (wr_op1 && !wr_op2) |=> (mode_q == $past(mode_d)) && !launch_q)
        else $error("first-operand write did not select mode cleanly");

    // Launch follows the second-operand write by exactly one edge
    launch_time_a: assert property (
        wr_op2 |=> launch_q ##1 prod_valid ##1 res_done_q)
        else $error("second-operand write did not launch the pipeline");

    // Results stored two edges after the write, inside the three allowed
    result_time_a: assert property (
        wr_op2 |-> ##2 (prod_valid && !res_done_q || prod_valid) ##1 res_done_q)
        else $error("result not ready within three cycles");

    // Nothing else disturbs the first operand or mode
    op1_keep_a: assert property (
        !wr_op1 |=> $stable(op1_q) && $stable(mode_q))
        else $error("first operand changed without a write");

    // Plain products land unchanged in the low and high words
    prod_words_a: assert property (
        (prod_valid && (prod_mode == mma_pkg::MMA_UMUL ||
                        prod_mode == mma_pkg::MMA_SMUL))
        |=> {res_q.hi, res_q.lo} == $past(prod))
        else $error("product words wrong");

    // Unsigned product clears the extension word
    umul_ext_a: assert property (
        (prod_valid && prod_mode == mma_pkg::MMA_UMUL) |=> res_q.ext == mma_pkg::EXT_ZERO)
        else $error("extension word not zero after unsigned product");

    // Signed modes copy the result sign across the extension word
    signed_ext_a: assert property (
        (prod_valid && (prod_mode == mma_pkg::MMA_SMUL ||
                        prod_mode == mma_pkg::MMA_SACC))
        |=> res_q.ext == (res_q.hi[15] ? mma_pkg::EXT_ONES : mma_pkg::EXT_ZERO))
        else $error("extension word does not follow result sign");

    // Unsigned accumulate: 33-bit sum split into carry and words
    uacc_carry_a: assert property (
        (prod_valid && prod_mode == mma_pkg::MMA_UACC)
        |=> {res_q.ext, res_q.hi, res_q.lo} ==
            {15'h0000, 33'({1'b0, $past(res_q.hi), $past(res_q.lo)} + {1'b0, $past(prod)})})
        else $error("unsigned accumulate sum or carry wrong");

    // Signed accumulate wraps at 32 bits with no flag
    sacc_wrap_a: assert property (
        (prod_valid && prod_mode == mma_pkg::MMA_SACC)
        |=> {res_q.hi, res_q.lo} == 32'({$past(res_q.hi), $past(res_q.lo)} + $past(prod)))
        else $error("signed accumulate did not wrap");

    // Signed byte first operand carries its sign into the upper byte
    byte_sign_a: assert property (
        (wr_op1 && bus_req.byte_acc && mode_signed)
        |=> op1_q == {{8{$past(bus_req.wdata[7])}}, $past(bus_req.wdata[7:0])})
        else $error("signed byte operand not sign-extended");

    // Unsigned byte first operand is zero-extended
    byte_zero_a: assert property (
        (wr_op1 && bus_req.byte_acc && !mode_signed)
        |=> op1_q[15:8] == mma_pkg::BYTE_ZERO)
        else $error("unsigned byte operand not zero-extended");

    // Main scenarios
    cov_sacc_neg_c: cover property (
        prod_valid && prod_mode == mma_pkg::MMA_SACC ##1 res_q.ext == mma_pkg::EXT_ONES);
    cov_uacc_carry_c: cover property (
        prod_valid && prod_mode == mma_pkg::MMA_UACC ##1 res_q.ext[0]);
    cov_back_to_back_c: cover property (wr_op2 ##1 wr_op2);
    cov_byte_signed_c: cover property (wr_op2 && bus_req.byte_acc && op2_signed);

endmodule
`default_nettype wire

/* File: verification/mma_cpu_model.sv */
// Processor core model issuing word and byte accesses to the peripheral
`timescale 1ns/10ps
`default_nettype none
module mma_cpu_model (
    // Clock
    input  wire logic                 ref_clk,
    // Bus towards the peripheral
    output var mma_pkg::mma_bus_req_t bus_req,
    input  wire logic [15:0]          rdata_q
);
    ////////////////////////////////////////////////////////////////////////////
    // Idle bus at time zero
    initial begin
        bus_req = '0;
    end

    // One access, then two idle cycles; the gap covers the result latency
    // Released address and data lines show inverted values so stale data never passes for valid; strobes drop to zero
    task automatic access(input logic [15:0] a, input logic [15:0] d, input logic w,
                          input logic bt, output logic [15:0] q);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: d, wen: w, ren: !w, byte_acc: bt};
        @(posedge ref_clk);
        bus_req <= '{addr: ~a, wdata: ~d, wen: 1'b0, ren: 1'b0, byte_acc: 1'b0};
        #1;
        q = rdata_q;
        // Second idle cycle: a result read is then sampled three edges after the write
        @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

/* File: verification/mma_top_bench.sv */
// Self-checking testbench of the multiply-accumulate peripheral
`timescale 1ns/10ps
`default_nettype none
module mma_top_bench;
    logic                  ref_clk;      // 20 MHz clock
    logic                  sys_rst;      // Active high reset
    mma_pkg::mma_bus_req_t bus_req;      // Driven by the core model
    logic [15:0]           rdata_q;      // Read data
    logic [15:0]           got;          // Last read value
    logic [15:0]           adr;          // Address walker
    logic [15:0]           opnd_a;       // Expected stored first operand
    logic [1:0]            cur_mode;     // 0 umul, 1 smul, 2 uacc, 3 sacc
    logic [31:0]           acc;          // Expected result high and low words
    logic [15:0]           ext_e;        // Expected extension word
    logic [31:0]           r;            // Random draws
    logic [31:0]           r2;
    int                    miscompares;
    int                    checks_done;
    int                    seed;

    mma_top mma_top_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_req(bus_req),
                          .rdata_q(rdata_q));
    mma_cpu_model mma_cpu_model_inst (.ref_clk(ref_clk), .bus_req(bus_req), .rdata_q(rdata_q));

    ////////////////////////////////////////////////////////////////////////////
    // Byte operands: sign or zero extension
    function automatic logic [15:0] widen(input logic [15:0] v, input logic bt, input logic sg);
        if (!bt) return v;
        return {(sg && v[7]) ? 8'hFF : 8'h00, v[7:0]};
    endfunction

    // Expected {ext, hi, lo} from mode, operands and held result
    function automatic logic [47:0] predict(input logic [1:0] m, input logic [15:0] a,
                                            input logic [15:0] b, input logic [31:0] prev);
        logic [31:0] p;
        logic [32:0] s;
        logic [15:0] e;
        p = m[0] ? {{16{a[15]}}, a} * {{16{b[15]}}, b} : {16'h0000, a} * {16'h0000, b};
        s = m[1] ? {1'b0, prev} + {1'b0, p} : {1'b0, p};
        e = (m == 2'd0) ? 16'h0000 : (m == 2'd2) ? {15'h0000, s[32]} :
            (s[31] ? 16'hFFFF : 16'h0000);
        return {e, s[31:0]};
    endfunction

    task automatic check(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic cpu(input logic [15:0] a, input logic [15:0] d, input logic w,
                       input logic bt);
        mma_cpu_model_inst.access(a, d, w, bt, got);
    endtask

    // Optional first operand write, launch, then read all three result words
    task automatic run(input logic [1:0] m, input logic [15:0] ar, input logic [15:0] br,
                       input logic ba, input logic bb, input logic wf);
        logic [15:0] b;
        logic [47:0] e;
        if (wf) begin
            cur_mode = m;
            opnd_a = widen(ar, ba, m[0]);
            adr = mma_pkg::ADDR_OP1_UMUL + {13'h0000, m, 1'b0};
            cpu(adr, ar, 1'b1, ba);
            cpu(adr, 16'h0000, 1'b0, 1'b0);
            check(got, opnd_a);
        end
        b = widen(br, bb, cur_mode[0]);
        cpu(mma_pkg::ADDR_OP2, br, 1'b1, bb);
        e = predict(cur_mode, opnd_a, b, acc);
        acc = e[31:0];
        ext_e = e[47:32];
        cpu(mma_pkg::ADDR_RES_LO, 16'h0000, 1'b0, 1'b0);
        check(got, e[15:0]);
        cpu(mma_pkg::ADDR_RES_HI, 16'h0000, 1'b0, 1'b0);
        check(got, e[31:16]);
        cpu(mma_pkg::ADDR_SUM_EXT, 16'h0000, 1'b0, 1'b0);
        check(got, e[47:32]);
    endtask

    // Software preload of the held result
    task automatic preload(input logic [31:0] v);
        cpu(mma_pkg::ADDR_RES_LO, v[15:0], 1'b1, 1'b0);
        cpu(mma_pkg::ADDR_RES_HI, v[31:16], 1'b1, 1'b0);
        acc = v;
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (50000) @(posedge ref_clk);
        miscompares++;
        give_verdict();
    end

    // Main sequence
    initial begin
        sys_rst = 1'b1;
        miscompares = 0;
        checks_done = 0;
        seed = 4;
        acc = 32'h0000_0000;
        opnd_a = 16'h0000;
        cur_mode = 2'd0;
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        adr = mma_pkg::ADDR_OP1_UMUL;
        for (int i = 0; i < 8; i++) begin
            cpu(adr, 16'h0000, 1'b0, 1'b0);
            check(got, mma_pkg::WORD_RESET);
            adr = adr + 16'h0002;
        end
        $display("test reset values done");
        run(2'd1, 16'hFFFE, 16'h0003, 1'b0, 1'b0, 1'b1);
        run(2'd0, 16'h0012, 16'h0034, 1'b1, 1'b1, 1'b1);
        run(2'd1, 16'h5A80, 16'hA5FF, 1'b1, 1'b1, 1'b1);
        run(2'd3, 16'h0080, 16'h0003, 1'b1, 1'b0, 1'b1);
        preload(32'h7FFF_FFFF);
        run(2'd3, 16'h0001, 16'h0001, 1'b0, 1'b0, 1'b1);
        preload(32'h8000_0000);
        run(2'd3, 16'hFFFF, 16'h0001, 1'b0, 1'b0, 1'b1);
        preload(32'hFFFF_FFFF);
        run(2'd2, 16'h0001, 16'h0001, 1'b0, 1'b0, 1'b1);
        run(2'd2, 16'hFFFF, 16'hFFFF, 1'b0, 1'b0, 1'b0);
        $display("test corner cases done");
        cpu(mma_pkg::ADDR_SUM_EXT, 16'h1234, 1'b1, 1'b0);
        cpu(mma_pkg::ADDR_SUM_EXT, 16'h0000, 1'b0, 1'b0);
        check(got, ext_e);
        cpu(16'h0131, 16'h0000, 1'b0, 1'b0);
        check(got, 16'h0000);
        cpu(16'h0140, 16'h0000, 1'b0, 1'b0);
        check(got, 16'h0000);
        cpu(mma_pkg::ADDR_RES_LO, 16'h0000, 1'b0, 1'b1);
        check(got, {8'h00, acc[7:0]});
        $display("test access kinds done");
        for (int i = 0; i < 200; i++) begin
            r = $random(seed);
            r2 = $random(seed);
            run(r[1:0], r[31:16], r2[15:0], r[2], r[3], r[4] || i == 0);
        end
        $display("test random operations done");
        give_verdict();
    end
endmodule
`default_nettype wire
